// ---- exec_pkg.sv ----
// constants, register map and types of the instruction execution block
package exec_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_INSTR = 8'h00; // issue an instruction
    localparam logic [7:0] OFS_STATUS = 8'h04; // flags, enable, busy
    localparam logic [7:0] OFS_WREG = 8'h08; // working register
    localparam logic [7:0] OFS_PC = 8'h0C; // program counter
    localparam logic [7:0] OFS_STACK = 8'h10; // push / stack pointer
    localparam logic [7:0] OFS_MPTR = 8'h14; // data memory pointer
    localparam logic [7:0] OFS_MDATA = 8'h18; // data memory window

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int IMM_LSB = 0; // immediate byte of an instruction
    localparam int ADR_LSB = 8; // memory address of an instruction
    localparam int OP_LSB = 16; // 5-bit operation code
    localparam int FLG_C = 0; // carry
    localparam int FLG_AC = 1; // auxiliary carry
    localparam int FLG_Z = 2; // zero
    localparam int FLG_OV = 3; // overflow
    localparam int ST_IRQ = 4; // global interrupt enable
    localparam int ST_BUSY = 5; // instruction in flight

    // ----------------------------------------------------------------
    // reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [11:0] PC_RST = 12'h000;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [2:0] SP_RST = 3'h0;
    localparam int STACK_DEPTH = 8;
    localparam int DMEM_DEPTH = 256;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 10; // system clock period
    localparam int INSTR_CYCLE_NS = 40; // one instruction cycle
    localparam logic [1:0] CYC_LAST = 2'((INSTR_CYCLE_NS + CLK_NS - 1) / CLK_NS - 1);

    // ----------------------------------------------------------------
    // operations and states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        op_nop = 5'h00, op_move_mem_to_w = 5'h01, op_move_imm_to_w = 5'h02,
        op_move_w_to_mem = 5'h03, op_or_mem = 5'h04, op_or_imm = 5'h05,
        op_or_into_memory = 5'h06, op_return = 5'h07, op_return_value = 5'h08,
        op_interrupt_return = 5'h09, op_rotate_left = 5'h0A,
        op_rotate_left_w = 5'h0B, op_rotate_left_carry = 5'h0C,
        op_rotate_left_carry_w = 5'h0D, op_rotate_right = 5'h0E,
        op_rotate_right_w = 5'h0F, op_rotate_right_carry = 5'h10,
        op_rotate_right_carry_w = 5'h11, op_subtract_with_borrow = 5'h12,
        op_subtract_borrow_to_memory = 5'h13, op_decrement_skip_zero = 5'h14,
        op_decrement_skip_zero_to_wreg = 5'h15
    } op_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00, st_exec = 2'b01, st_second = 2'b10, st_dummy = 2'b11
    } state_t;
endpackage : exec_pkg

// ---- exec_unit.sv ----
// instruction execution unit with its Avalon-MM register slave
`timescale 1ns/1ps
module exec_unit (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    // ----------------------------------------------------------------
    // arithmetic helpers
    // ----------------------------------------------------------------
    // a + ~m + c; returns {ov, ac, c, result}
    function automatic logic [10:0] sub_borrow(input logic [7:0] a,
                                               input logic [7:0] m,
                                               input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] lower7;
        logic c7;
        full = {1'b0, a} + {1'b0, ~m} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cin};
        lower7 = {1'b0, a[6:0]} + {1'b0, ~m[6:0]} + {7'h00, cin};
        c7 = lower7[7];
        return {c7 ^ full[8], low[4], full[8], full[7:0]};
    endfunction : sub_borrow

    // one-bit rotate; returns {carry_out, result}
    function automatic logic [8:0] rotate(input logic [7:0] d,
                                          input logic cin,
                                          input logic left,
                                          input logic thru);
        logic fill;
        fill = left ? d[7] : d[0];
        if (thru) begin
            fill = cin;
        end
        if (left) begin
            return {d[7], d[6:0], fill};
        end
        return {d[0], fill, d[7:1]};
    endfunction : rotate

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    exec_pkg::state_t state_r; // execution sequencer
    logic [1:0] div_r; // instruction cycle divider
    logic cyc_tick; // one pulse per instruction cycle
    exec_pkg::op_t op_r; // operation in flight
    logic [7:0] imm_r; // its immediate byte
    logic [7:0] adr_r; // its memory address
    logic [7:0] wreg_r; // working register
    logic [3:0] flags_r; // ov, z, ac, c
    logic irq_en_r; // global interrupt enable
    logic [11:0] pc_r; // program counter
    logic [2:0] sp_r; // stack pointer, next free slot
    logic [11:0] stack_r [exec_pkg::STACK_DEPTH]; // return stack
    logic [7:0] dmem [exec_pkg::DMEM_DEPTH]; // data memory
    logic [7:0] mptr_r; // software window pointer
    logic rd_valid_r; // read answer ready
    logic [31:0] readdata_r; // registered read data
    logic busy; // instruction in flight
    logic fire; // first instruction cycle ends now
    logic wr_ok; // write accepted this cycle
    logic [7:0] mem_rd; // operand byte
    logic [11:0] stack_top; // entry a return pops

    // ----------------------------------------------------------------
    // results of the operation in flight
    // ----------------------------------------------------------------
    logic [7:0] res; // value written back
    logic we_w; // write back to working register
    logic we_m; // write back to memory
    logic [3:0] flags_nxt; // flags after execution
    logic skip; // discard the next fetched instruction
    logic pops; // a return of any kind
    logic two_cycle; // needs a second instruction cycle

    assign busy = (state_r != exec_pkg::st_idle);
    assign cyc_tick = (div_r == exec_pkg::CYC_LAST);
    assign fire = (state_r == exec_pkg::st_exec) && cyc_tick;
    assign wr_ok = write && !busy;
    assign mem_rd = dmem[adr_r];
    assign stack_top = stack_r[3'(sp_r - 3'h1)];

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    // reads wait one cycle so data come from a flop; writes stall
    // while an instruction runs, so software never races the datapath
    assign waitrequest = (read && !rd_valid_r) || (write && busy);
    assign readdata = readdata_r;

    // free-running divider gives the instruction cycle rate
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            div_r <= 2'h0;
        end else if (cyc_tick) begin
            div_r <= 2'h0;
        end else begin
            div_r <= 2'(div_r + 2'h1);
        end
    end

    // decode and compute, all in one place per operation
    always_comb begin
        logic [10:0] sb;
        logic [8:0] rt;
        logic [7:0] dec;
        sb = sub_borrow(wreg_r, mem_rd, flags_r[exec_pkg::FLG_C]);
        rt = 9'h000;
        dec = 8'(mem_rd - 8'h01);
        res = 8'h00;
        we_w = 1'b0;
        we_m = 1'b0;
        flags_nxt = flags_r;
        skip = 1'b0;
        pops = 1'b0;
        two_cycle = 1'b0;
        unique case (op_r)
            exec_pkg::op_nop: begin
                res = 8'h00;
            end
            exec_pkg::op_move_mem_to_w: begin
                res = mem_rd;
                we_w = 1'b1;
            end
            exec_pkg::op_move_imm_to_w: begin
                res = imm_r;
                we_w = 1'b1;
            end
            exec_pkg::op_move_w_to_mem: begin
                res = wreg_r;
                we_m = 1'b1;
            end
            exec_pkg::op_or_mem, exec_pkg::op_or_imm,
            exec_pkg::op_or_into_memory: begin
                res = wreg_r | ((op_r == exec_pkg::op_or_imm) ? imm_r : mem_rd);
                we_m = (op_r == exec_pkg::op_or_into_memory);
                we_w = !we_m;
                flags_nxt[exec_pkg::FLG_Z] = (res == 8'h00);
            end
            exec_pkg::op_return, exec_pkg::op_interrupt_return: begin
                pops = 1'b1;
                two_cycle = 1'b1;
            end
            exec_pkg::op_return_value: begin
                pops = 1'b1;
                two_cycle = 1'b1;
                res = imm_r;
                we_w = 1'b1;
            end
            exec_pkg::op_rotate_left, exec_pkg::op_rotate_left_w,
            exec_pkg::op_rotate_left_carry, exec_pkg::op_rotate_left_carry_w,
            exec_pkg::op_rotate_right, exec_pkg::op_rotate_right_w,
            exec_pkg::op_rotate_right_carry,
            exec_pkg::op_rotate_right_carry_w: begin
                // code bit 0 picks the register target, bit 1 clear picks
                // the carry path; the compare picks the direction
                rt = rotate(mem_rd, flags_r[exec_pkg::FLG_C],
                            (op_r < exec_pkg::op_rotate_right), !op_r[1]);
                res = rt[7:0];
                we_w = op_r[0];
                we_m = !op_r[0];
                if (!op_r[1]) begin
                    flags_nxt[exec_pkg::FLG_C] = rt[8];
                end
            end
            exec_pkg::op_subtract_with_borrow,
            exec_pkg::op_subtract_borrow_to_memory: begin
                res = sb[7:0];
                we_m = op_r[0];
                we_w = !op_r[0];
                flags_nxt = {sb[10], (sb[7:0] == 8'h00), sb[9], sb[8]};
            end
            exec_pkg::op_decrement_skip_zero,
            exec_pkg::op_decrement_skip_zero_to_wreg: begin
                res = dec;
                we_w = op_r[0];
                we_m = !op_r[0];
                skip = (dec == 8'h00);
            end
            default: begin
                res = 8'h00; // unknown codes behave as a no-op
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // an issue runs until the next cycle boundary and executes there;
    // returns and taken skips hold busy for exactly one more cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_r <= exec_pkg::st_idle;
        end else begin
            unique case (state_r)
                exec_pkg::st_idle: begin
                    if (wr_ok && address == exec_pkg::OFS_INSTR) begin
                        state_r <= exec_pkg::st_exec;
                    end
                end
                exec_pkg::st_exec: begin
                    if (cyc_tick && skip) begin
                        state_r <= exec_pkg::st_dummy;
                    end else if (cyc_tick && two_cycle) begin
                        state_r <= exec_pkg::st_second;
                    end else if (cyc_tick) begin
                        state_r <= exec_pkg::st_idle;
                    end
                end
                exec_pkg::st_second, exec_pkg::st_dummy: begin
                    if (cyc_tick) begin
                        state_r <= exec_pkg::st_idle;
                    end
                end
            endcase
        end
    end

    // latch the issued instruction fields
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            op_r <= exec_pkg::op_nop;
            imm_r <= 8'h00;
            adr_r <= 8'h00;
        end else if (wr_ok && address == exec_pkg::OFS_INSTR) begin
            op_r <= exec_pkg::op_t'(writedata[exec_pkg::OP_LSB +: 5]);
            imm_r <= writedata[exec_pkg::IMM_LSB +: 8];
            adr_r <= writedata[exec_pkg::ADR_LSB +: 8];
        end
    end

    // ----------------------------------------------------------------
    // architectural registers
    // ----------------------------------------------------------------
    // working register: datapath result or software write
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wreg_r <= exec_pkg::WREG_RST;
        end else if (fire && we_w) begin
            wreg_r <= res;
        end else if (wr_ok && address == exec_pkg::OFS_WREG) begin
            wreg_r <= writedata[7:0];
        end
    end

    // flags: only the fields an operation names ever change
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            flags_r <= exec_pkg::FLAGS_RST;
        end else if (fire) begin
            flags_r <= flags_nxt;
        end else if (wr_ok && address == exec_pkg::OFS_STATUS) begin
            flags_r <= writedata[3:0];
        end
    end

    // global interrupt enable
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            irq_en_r <= 1'b0;
        end else if (fire && op_r == exec_pkg::op_interrupt_return) begin
            irq_en_r <= 1'b1;
        end else if (wr_ok && address == exec_pkg::OFS_STATUS) begin
            irq_en_r <= writedata[exec_pkg::ST_IRQ];
        end
    end

    // program counter: +1 per executed instruction and per skipped slot, returns load the stack top
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pc_r <= exec_pkg::PC_RST;
        end else if (fire && pops) begin
            pc_r <= stack_top;
        end else if (fire || (state_r == exec_pkg::st_dummy && cyc_tick)) begin
            pc_r <= 12'(pc_r + 12'h001);
        end else if (wr_ok && address == exec_pkg::OFS_PC) begin
            pc_r <= writedata[11:0];
        end
    end

    // stack pointer wraps: over- and underflow overwrite silently
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sp_r <= exec_pkg::SP_RST;
        end else if (fire && pops) begin
            sp_r <= 3'(sp_r - 3'h1);
        end else if (wr_ok && address == exec_pkg::OFS_STACK) begin
            sp_r <= 3'(sp_r + 3'h1);
        end
    end

    // stack entries are written only by a software push
    always_ff @(posedge clk_sys) begin
        if (wr_ok && address == exec_pkg::OFS_STACK) begin
            stack_r[sp_r] <= writedata[11:0];
        end
    end

    // data memory: datapath write-back or software window
    always_ff @(posedge clk_sys) begin
        if (fire && we_m) begin
            dmem[adr_r] <= res;
        end else if (wr_ok && address == exec_pkg::OFS_MDATA) begin
            dmem[mptr_r] <= writedata[7:0];
        end
    end

    // memory window pointer
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mptr_r <= 8'h00;
        end else if (wr_ok && address == exec_pkg::OFS_MPTR) begin
            mptr_r <= writedata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // unmapped offsets read zero; the answer lands one cycle later
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rd_valid_r <= 1'b0;
            readdata_r <= 32'h00000000;
        end else begin
            rd_valid_r <= read && !rd_valid_r;
            if (read && !rd_valid_r) begin
                unique case (address)
                    exec_pkg::OFS_STATUS: readdata_r <= {26'h0, busy, irq_en_r, flags_r};
                    exec_pkg::OFS_WREG: readdata_r <= {24'h0, wreg_r};
                    exec_pkg::OFS_PC: readdata_r <= {20'h0, pc_r};
                    exec_pkg::OFS_STACK: readdata_r <= {29'h0, sp_r};
                    exec_pkg::OFS_MPTR: readdata_r <= {24'h0, mptr_r};
                    exec_pkg::OFS_MDATA: readdata_r <= {24'h0, dmem[mptr_r]};
                    default: readdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_fire(exec_pkg::op_t o);
        fire && op_r == o;
    endsequence
    sequence s_extra(exec_pkg::state_t s);
        (state_r == s) [*4] ##1 (state_r == exec_pkg::st_idle);
    endsequence

    AST_MOVE_MEM: assert property (s_fire(exec_pkg::op_move_mem_to_w) |=>
        wreg_r == $past(mem_rd) && $stable(flags_r))
        else $error("memory move to working register wrong");
    AST_MOVE_IMM: assert property (s_fire(exec_pkg::op_move_imm_to_w) |=>
        wreg_r == $past(imm_r) && $stable(flags_r))
        else $error("immediate move wrong");
    AST_MOVE_TO_MEM: assert property (s_fire(exec_pkg::op_move_w_to_mem) |=>
        dmem[adr_r] == $past(wreg_r) && $stable(flags_r))
        else $error("store of working register wrong");
    AST_NOP: assert property (s_fire(exec_pkg::op_nop) |=>
        pc_r == 12'($past(pc_r) + 12'h001) && $stable(wreg_r) && $stable(flags_r))
        else $error("no-op changed state");
    AST_OR_ZERO: assert property (s_fire(exec_pkg::op_or_into_memory) |=>
        dmem[adr_r] == ($past(wreg_r) | $past(mem_rd))
        && flags_r[exec_pkg::FLG_Z] == (dmem[adr_r] == 8'h00)
        && flags_r[1:0] == $past(flags_r[1:0]))
        else $error("or into memory wrong");
    AST_RET_TWO: assert property (s_fire(exec_pkg::op_return) |=>
        pc_r == $past(stack_top) ##0 s_extra(exec_pkg::st_second))
        else $error("return not two cycles");
    AST_INTERRUPT_RETURN_EN: assert property (s_fire(exec_pkg::op_interrupt_return) |=>
        irq_en_r && pc_r == $past(stack_top))
        else $error("interrupt return did not enable");
    AST_ROT_LEFT: assert property (s_fire(exec_pkg::op_rotate_left) |=>
        dmem[adr_r] == {$past(mem_rd[6:0]), $past(mem_rd[7])} && $stable(flags_r))
        else $error("left rotate wrong");
    AST_ROT_RC_W: assert property (s_fire(exec_pkg::op_rotate_right_carry_w) |=>
        wreg_r == {$past(flags_r[0]), $past(mem_rd[7:1])}
        && flags_r[0] == $past(mem_rd[0]) && $stable(mem_rd))
        else $error("right rotate through carry wrong");
    AST_SUB_BORROW: assert property (s_fire(exec_pkg::op_subtract_with_borrow) |=>
        wreg_r == 8'($past(wreg_r) + ~$past(mem_rd) + {7'h00, $past(flags_r[0])}))
        else $error("subtract with borrow wrong");
    AST_SKIP_DUMMY: assert property (fire && skip |=>
        s_extra(exec_pkg::st_dummy) ##0 pc_r == 12'($past(pc_r, 6) + 12'h002))
        else $error("taken skip not two cycles");
endmodule : exec_unit

// ---- cpu_move_logic_rotate_return_exec_tb_top.sv ----
// self-checking bench of the instruction execution unit
`timescale 1ns/1ps
module cpu_move_logic_rotate_return_exec_tb_top;
    logic clk_sys, rstn, read, write, waitrequest;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rnd;
    logic [31:0] exp_q[$]; // expected read data, oldest first
    string nm_q[$]; // what each expected value stands for
    int err_total, cmp_count, stall;
    // ----------------------------------------
    // clock and design
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    exec_unit i_dut (.clk_sys(clk_sys), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // bus write; one idle edge after release so write never toggles twice in a step
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        stall = 0;
        @(posedge clk_sys);
        while (waitrequest !== 1'b0 && stall < 100) begin
            stall++;
            @(posedge clk_sys);
        end
        write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus_wr
    // bus read; the monitor compares at the accepting edge
    task automatic bus_rd(input logic [7:0] a, input string nm, input logic [31:0] e);
        int n = 0;
        exp_q.push_back(e);
        nm_q.push_back(nm);
        address <= a;
        read <= 1'b1;
        @(posedge clk_sys);
        while (waitrequest !== 1'b0 && n < 100) begin
            n++;
            @(posedge clk_sys);
        end
        read <= 1'b0;
        @(posedge clk_sys);
    endtask : bus_rd
    always @(posedge clk_sys) begin
        if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0)
            check(nm_q.pop_front(), readdata, exp_q.pop_front());
    end
    // ----------------------------------------
    // reference: returns {pc, status, mem, wreg}
    // ----------------------------------------
    function automatic logic [32:0] model(input logic [4:0] op, input logic [7:0] w, m, imm,
        input logic [4:0] st, input logic [11:0] pc, top);
        logic [8:0] s;
        logic [4:0] lo, ns;
        logic [7:0] c6, nw, nm, d;
        logic [11:0] np;
        s = {1'b0, w} + {1'b0, ~m} + 9'(st[0]);
        lo = {1'b0, w[3:0]} + {1'b0, ~m[3:0]} + 5'(st[0]);
        c6 = {1'b0, w[6:0]} + {1'b0, ~m[6:0]} + 8'(st[0]);
        d = m - 8'h01;
        nw = w;
        nm = m;
        ns = st;
        np = pc + 12'h001;
        case (op)
            5'h01: nw = m;
            5'h02, 5'h08: nw = imm;
            5'h03: nm = w;
            5'h04, 5'h05: nw = w | ((op == 5'h04) ? m : imm);
            5'h06: nm = w | m;
            5'h0A: nm = {m[6:0], m[7]};
            5'h0B: nw = {m[6:0], m[7]};
            5'h0C: nm = {m[6:0], st[0]};
            5'h0D: nw = {m[6:0], st[0]};
            5'h0E: nm = {m[0], m[7:1]};
            5'h0F: nw = {m[0], m[7:1]};
            5'h10: nm = {st[0], m[7:1]};
            5'h11: nw = {st[0], m[7:1]};
            5'h12: nw = s[7:0];
            5'h13: nm = s[7:0];
            5'h14: nm = d;
            5'h15: nw = d;
            default: ;
        endcase
        if (op inside {5'h07, 5'h08, 5'h09}) np = top;
        if (op == 5'h09) ns[4] = 1'b1;
        if (op == 5'h06) ns[2] = (nm == 8'h00);
        if (op inside {5'h04, 5'h05}) ns[2] = (nw == 8'h00);
        if (op inside {5'h0C, 5'h0D}) ns[0] = m[7];
        if (op inside {5'h10, 5'h11}) ns[0] = m[0];
        if (op inside {5'h12, 5'h13}) ns[3:0] = {c6[7] ^ s[8], s[7:0] == 8'h00, lo[4], s[8]};
        if (op inside {5'h14, 5'h15} && d == 8'h00) np = pc + 12'h002;
        return {np, ns, nm, nw};
    endfunction : model
    initial begin
        repeat (30000) @(posedge clk_sys);
        err_total++;
        end_sim();
    end
    initial begin
        logic [7:0] w, m, a, imm;
        logic [4:0] st;
        logic [11:0] pc, top;
        logic [32:0] e;
        logic ext;
        rstn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        rnd = 32'h6F8F;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        bus_rd(exec_pkg::OFS_WREG, "wreg", {24'h0, exec_pkg::WREG_RST});
        bus_rd(exec_pkg::OFS_PC, "pc", {20'h0, exec_pkg::PC_RST});
        bus_rd(exec_pkg::OFS_STATUS, "status", {28'h0, exec_pkg::FLAGS_RST});
        bus_wr(8'h1C, 32'hFFFF_FFFF);
        bus_rd(8'h1C, "unmapped", 32'h0);
        $display("test done reset values");
        // every op code, first pass with memory 1 so decrements reach zero
        for (int o = 0; o < 22; o++) begin
            for (int r = 0; r < 3; r++) begin
                repeat (9) rnd = lfsr(rnd);
                {imm, a, m, w} = rnd;
                if (r == 0) m = 8'h01;
                repeat (9) rnd = lfsr(rnd);
                {top, pc, st} = rnd[28:0];
                e = model(5'(o), w, m, imm, st, pc, top);
                bus_wr(exec_pkg::OFS_PC, {20'h0, pc});
                bus_wr(exec_pkg::OFS_STACK, {20'h0, top});
                bus_wr(exec_pkg::OFS_WREG, {24'h0, w});
                bus_wr(exec_pkg::OFS_MPTR, {24'h0, a});
                bus_wr(exec_pkg::OFS_MDATA, {24'h0, m});
                bus_wr(exec_pkg::OFS_STATUS, {27'h0, st});
                bus_wr(exec_pkg::OFS_INSTR, {11'h0, 5'(o), a, imm});
                // unmapped write stalls until the instruction has retired
                bus_wr(8'h1C, 32'h0);
                ext = (o inside {7, 8, 9}) || (e[32:21] == pc + 12'h002);
                check("stall", 32'(ext ? (stall >= 4 && stall <= 7) : (stall <= 3)), 32'h1);
                bus_rd(exec_pkg::OFS_WREG, "wreg", {24'h0, e[7:0]});
                bus_rd(exec_pkg::OFS_MDATA, "mem", {24'h0, e[15:8]});
                bus_rd(exec_pkg::OFS_STATUS, "status", {27'h0, e[20:16]});
                bus_rd(exec_pkg::OFS_PC, "pc", {20'h0, e[32:21]});
            end
            $display("test done op %0d", o);
        end
        end_sim();
    end
endmodule : cpu_move_logic_rotate_return_exec_tb_top
